// file: hdl/deir_pkg.sv
// Constants and types shared by the event status and interrupt routing block
package deir_pkg;

  typedef logic [7:0] deir_byte_t;

  localparam int         ADDR_W = 8;
  localparam int         GROUPS = 4;
  localparam deir_byte_t RESET_VALUE = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam deir_byte_t OFS_LINK_EVENT_LATCH       = 8'h20;
  localparam deir_byte_t OFS_LINK_EVENT_FLAGS       = 8'h24;
  localparam deir_byte_t OFS_DAC0_EVENT_FLAGS       = 8'h25;
  localparam deir_byte_t OFS_DAC1_EVENT_FLAGS       = 8'h26;
  localparam deir_byte_t OFS_CLOCK_LOCK_EVENT_FLAGS = 8'h27;
  localparam deir_byte_t OFS_LINK_EVENT_PIN_SELECT  = 8'h28;
  localparam deir_byte_t OFS_DAC0_EVENT_PIN_SELECT  = 8'h29;
  localparam deir_byte_t OFS_DAC1_EVENT_PIN_SELECT  = 8'h2A;
  localparam deir_byte_t OFS_EVENT_SUMMARY          = 8'h2C;

  //////////////////////////////////////////////////////////////////////////////
  // Bit positions inside each group
  localparam int BIT_PATTERN_ERR_CH0     = 0;
  localparam int BIT_PATTERN_ERR_CH1     = 1;
  localparam int BIT_LANE_BUFFER_FAULT   = 2;
  localparam int BIT_RX_NOT_READY        = 3;
  localparam int BIT_SYNC_REF_JITTER     = 4;
  localparam int BIT_AMP_PROTECT         = 0;
  localparam int BIT_CAL_DONE            = 3;
  localparam int BIT_SYNTH_LOCKED        = 0;
  localparam int BIT_SYNTH_UNLOCKED      = 1;
  localparam int BIT_DELAY_LOOP_LOCKED   = 4;
  localparam int BIT_DELAY_LOOP_UNLOCKED = 5;
  localparam int BIT_SUMMARY             = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Implemented bits per group; everything else is reserved
  localparam deir_byte_t MASK_LINK  = 8'h1F;
  localparam deir_byte_t MASK_DAC   = 8'h09;
  localparam deir_byte_t MASK_CLOCK = 8'h33;
  localparam logic [31:0] MASK_ALL  = {MASK_CLOCK, MASK_DAC, MASK_DAC, MASK_LINK};

endpackage

// file: hdl/deir_flag_cell.sv
// One event status bit with live or latched behaviour
`timescale 1ns/1ps
module deir_flag_cell (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  // Event and control
  input  wire logic live_in,
  input  wire logic latch_en_in,
  input  wire logic clear_in,
  // Status
  output logic      status_out,
  output logic      pending_out
);

  logic latched_q;
  logic latched_d;

  // Set wins over a clear in the same cycle, so no event is lost
  assign latched_d = latch_en_in & (live_in | (latched_q & ~clear_in));

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      latched_q <= 1'b0;
    end else begin
      latched_q <= latched_d;
    end
  end

  // Live view while not latching
  assign status_out  = latch_en_in ? latched_q : live_in;
  assign pending_out = latch_en_in & latched_q;

endmodule

// file: hdl/deir_router.sv
// Event status, latch enable and pin routing for two active-low interrupt pins
`timescale 1ns/1ps
module deir_router (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rstn_in,
  // Register port
  input  wire logic [deir_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [7:0]                 wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [7:0]                 rdata_out,
  // Link events
  input  wire logic                       pattern_err_ch0_in,
  input  wire logic                       pattern_err_ch1_in,
  input  wire logic                       lane_buffer_fault_in,
  input  wire logic                       rx_not_ready_in,
  input  wire logic                       sync_ref_jitter_in,
  // Converter channel events
  input  wire logic                       cal_done_ch0_in,
  input  wire logic                       amp_protect_ch0_in,
  input  wire logic                       cal_done_ch1_in,
  input  wire logic                       amp_protect_ch1_in,
  // Clock lock events
  input  wire logic                       synth_locked_in,
  input  wire logic                       synth_unlocked_in,
  input  wire logic                       delay_loop_locked_in,
  input  wire logic                       delay_loop_unlocked_in,
  // Interrupt pins
  output logic                            int_out_a_n,
  output logic                            int_out_b_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic [deir_pkg::GROUPS-1:0] group_hit(
    input logic [deir_pkg::ADDR_W-1:0] addr,
    input logic [deir_pkg::ADDR_W-1:0] base
  );
    logic [deir_pkg::GROUPS-1:0] hit;
    hit = '0;
    for (int g = 0; g < deir_pkg::GROUPS; g++) begin
      hit[g] = (addr == (base + 8'(g)));
    end
    return hit;
  endfunction

  function automatic deir_pkg::deir_byte_t group_mask(input int g);
    return deir_pkg::MASK_ALL[8*g +: 8];
  endfunction

  logic [deir_pkg::GROUPS-1:0] latch_hit;
  logic [deir_pkg::GROUPS-1:0] flag_hit;
  logic [deir_pkg::GROUPS-1:0] pinsel_hit;
  logic                        summary_hit;
  logic [1:0]                  grp_idx;

  assign latch_hit   = group_hit(addr_in, deir_pkg::OFS_LINK_EVENT_LATCH);
  assign flag_hit    = group_hit(addr_in, deir_pkg::OFS_LINK_EVENT_FLAGS);
  assign pinsel_hit  = group_hit(addr_in, deir_pkg::OFS_LINK_EVENT_PIN_SELECT);
  assign summary_hit = (addr_in == deir_pkg::OFS_EVENT_SUMMARY);
  assign grp_idx     = addr_in[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Raw event vector, one byte per status register

  logic [7:0]  raw_link;
  logic [7:0]  raw_dac0;
  logic [7:0]  raw_dac1;
  logic [7:0]  raw_clock;
  logic [31:0] raw_all;

  assign raw_link  = {3'h0, sync_ref_jitter_in, rx_not_ready_in,
                      lane_buffer_fault_in, pattern_err_ch1_in,
                      pattern_err_ch0_in};
  assign raw_dac0  = {4'h0, cal_done_ch0_in, 2'h0, amp_protect_ch0_in};
  assign raw_dac1  = {4'h0, cal_done_ch1_in, 2'h0, amp_protect_ch1_in};
  assign raw_clock = {2'h0, delay_loop_unlocked_in, delay_loop_locked_in,
                      2'h0, synth_unlocked_in, synth_locked_in};
  assign raw_all   = {raw_clock, raw_dac1, raw_dac0, raw_link};

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers: conditions come from other clock domains

  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  logic [31:0] sync3_q;
  logic [31:0] filt_q;
  logic [31:0] filt_d;
  logic [31:0] sync_diff;

  // A change counts only once the second and third stages agree
  assign sync_diff = sync2_q ^ sync3_q;
  assign filt_d    = ((sync2_q & ~sync_diff) | (filt_q & sync_diff)) & deir_pkg::MASK_ALL;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
    end else begin
      sync1_q <= raw_all;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latch enable and pin select registers

  deir_pkg::deir_byte_t latch_en_q [deir_pkg::GROUPS];
  deir_pkg::deir_byte_t pinsel_q   [deir_pkg::GROUPS];
  deir_pkg::deir_byte_t status_grp [deir_pkg::GROUPS];
  logic [31:0]          en_all;
  logic [31:0]          pin_all;
  logic [31:0]          status_all;
  logic [31:0]          pending_all;
  logic [31:0]          clear_all;
  logic                 summary_clear;

  // One write of one to summary bit 0 clears every latched bit whose condition is low at once
  assign summary_clear = wr_in & summary_hit & wdata_in[deir_pkg::BIT_SUMMARY];

  for (genvar g = 0; g < deir_pkg::GROUPS; g++) begin : g_grp
    // Reserved bits are masked, so they never store a one
    always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        latch_en_q[g] <= deir_pkg::RESET_VALUE;
      end else if (wr_in && latch_hit[g]) begin
        latch_en_q[g] <= wdata_in & group_mask(g);
      end
    end

    // Group 3 select register (0x2B) has no offset in the map but is written like the rest
    always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        pinsel_q[g] <= deir_pkg::RESET_VALUE;
      end else if (wr_in && pinsel_hit[g]) begin
        pinsel_q[g] <= wdata_in & group_mask(g);
      end
    end

    assign en_all[8*g +: 8]    = latch_en_q[g];
    assign pin_all[8*g +: 8]   = pinsel_q[g];
    assign status_grp[g]       = status_all[8*g +: 8];
    assign clear_all[8*g +: 8] = ((wr_in && flag_hit[g]) ? wdata_in : 8'h00)
                                 | {8{summary_clear}};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status bits

  for (genvar i = 0; i < 32; i++) begin : g_bit
    if (deir_pkg::MASK_ALL[i]) begin : g_cell
      deir_flag_cell u_cell (
        .mclk_in     (mclk_in),
        .rstn_in     (rstn_in),
        .live_in     (filt_q[i]),
        .latch_en_in (en_all[i]),
        .clear_in    (clear_all[i]),
        .status_out  (status_all[i]),
        .pending_out (pending_all[i])
      );
    end else begin : g_rsvd
      assign status_all[i]  = 1'b0;
      assign pending_all[i] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt routing

  logic req_a;
  logic req_b;
  logic int_a_n_q;
  logic int_b_n_q;

  assign req_a = |(pending_all & ~pin_all);
  assign req_b = |(pending_all & pin_all);

  // Registered so the pins never glitch on select changes
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_a_n_q <= 1'b1;
      int_b_n_q <= 1'b1;
    end else begin
      int_a_n_q <= ~req_a;
      int_b_n_q <= ~req_b;
    end
  end

  assign int_out_a_n = int_a_n_q;
  assign int_out_b_n = int_b_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  logic                 summary;
  deir_pkg::deir_byte_t rd_mux;
  deir_pkg::deir_byte_t rdata_q;

  assign summary = |status_all;
  assign rd_mux  = (|latch_hit)  ? latch_en_q[grp_idx] :
                   (|flag_hit)   ? status_grp[grp_idx] :
                   (|pinsel_hit) ? pinsel_q[grp_idx]   :
                   summary_hit   ? {7'h00, summary}    :
                                   8'h00;

  // Data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= deir_pkg::RESET_VALUE;
    end else begin
      rdata_q <= rd_in ? rd_mux : deir_pkg::RESET_VALUE;
    end
  end

  assign rdata_out = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  live_read_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_LINK_EVENT_FLAGS && !en_all[0]
    |=> rdata_out[deir_pkg::BIT_PATTERN_ERR_CH0] == $past(filt_q[0]))
    else $error("live status not read back");

  latch_pin_a: assert property (
    (en_all[0] && filt_q[0]) ##1 (en_all[0] && !pin_all[0])
    |=> !int_out_a_n)
    else $error("latched event did not pull pin A low");

  wr_one_clear_a: assert property (
    wr_in && flag_hit[0] && wdata_in[0] && en_all[0] && !filt_q[0]
    |=> !status_all[0])
    else $error("write one did not clear status");

  wr_zero_keep_a: assert property (
    wr_in && flag_hit[0] && !wdata_in[0] && pending_all[0] && en_all[0]
    |=> status_all[0])
    else $error("write zero changed status");

  route_b_a: assert property (
    pending_all[8] && pin_all[8] |=> !int_out_b_n)
    else $error("selected event not on pin B");

  cal_done_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_DAC0_EVENT_FLAGS && !en_all[11]
    |=> rdata_out[deir_pkg::BIT_CAL_DONE] == $past(filt_q[11]))
    else $error("calibration done not at bit 3");

  synth_lost_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_CLOCK_LOCK_EVENT_FLAGS && !en_all[25]
    |=> rdata_out[deir_pkg::BIT_SYNTH_UNLOCKED] == $past(filt_q[25]))
    else $error("synthesizer lock lost not at bit 1");

  summary_or_a: assert property (
    rd_in && summary_hit |=> rdata_out[0] == $past(summary))
    else $error("summary is not the OR of status");

  summary_clear_a: assert property (
    summary_clear && filt_q == 32'h00000000 |=> pending_all == 32'h00000000)
    else $error("summary write left a latched bit");

  pin_release_a: assert property (
    pending_all == 32'h00000000 |=> int_out_a_n && int_out_b_n)
    else $error("pin held low with nothing pending");

  reserved_zero_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_DAC1_EVENT_PIN_SELECT
    |=> rdata_out[7:4] == 4'h0 && rdata_out[2:1] == 2'h0)
    else $error("reserved bits read non-zero");

  rd_only_once_a: assert property (
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside its cycle");

  amp0_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_DAC0_EVENT_FLAGS && !en_all[8]
    |=> rdata_out[deir_pkg::BIT_AMP_PROTECT] == $past(filt_q[8]))
    else $error("channel 0 amplifier error not at bit 0");

  cal1_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_DAC1_EVENT_FLAGS && !en_all[19]
    |=> rdata_out[deir_pkg::BIT_CAL_DONE] == $past(filt_q[19]))
    else $error("channel 1 calibration done not at bit 3");

  amp1_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_DAC1_EVENT_FLAGS && !en_all[16]
    |=> rdata_out[deir_pkg::BIT_AMP_PROTECT] == $past(filt_q[16]))
    else $error("channel 1 amplifier error not at bit 0");

  loop_lost_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_CLOCK_LOCK_EVENT_FLAGS && !en_all[29]
    |=> rdata_out[deir_pkg::BIT_DELAY_LOOP_UNLOCKED] == $past(filt_q[29]))
    else $error("delay loop lock lost not at bit 5");

  loop_lock_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_CLOCK_LOCK_EVENT_FLAGS && !en_all[28]
    |=> rdata_out[deir_pkg::BIT_DELAY_LOOP_LOCKED] == $past(filt_q[28]))
    else $error("delay loop locked not at bit 4");

  synth_lock_bit_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_CLOCK_LOCK_EVENT_FLAGS && !en_all[24]
    |=> rdata_out[deir_pkg::BIT_SYNTH_LOCKED] == $past(filt_q[24]))
    else $error("synthesizer locked not at bit 0");

  link_bits_a: assert property (
    rd_in && addr_in == deir_pkg::OFS_LINK_EVENT_FLAGS && en_all[4:0] == 5'h00
    |=> rdata_out[4:0] == $past(filt_q[4:0]))
    else $error("link status bits misplaced");

  link_sel_a: assert property (
    wr_in && pinsel_hit[0] |=> pin_all[4:0] == $past(wdata_in[4:0]))
    else $error("link pin select not stored");

  dac0_sel_a: assert property (
    wr_in && pinsel_hit[1]
    |=> pin_all[11] == $past(wdata_in[3]) && pin_all[8] == $past(wdata_in[0]))
    else $error("channel 0 pin select not stored");

  dac1_sel_a: assert property (
    wr_in && pinsel_hit[2] |=> pin_all[19] == $past(wdata_in[3]))
    else $error("channel 1 pin select not stored");

  latch_en_wr_a: assert property (
    wr_in && latch_hit[3]
    |=> en_all[31:24] == ($past(wdata_in) & deir_pkg::MASK_CLOCK))
    else $error("clock lock latch enables not stored");

  route_a_a: assert property (
    pending_all[0] && !pin_all[0] |=> !int_out_a_n)
    else $error("selected event not on pin A");

  live_follow_a: assert property (
    !en_all[29] |-> status_all[29] == filt_q[29])
    else $error("status does not follow live condition");

endmodule

// file: testbench/deir_host_model.sv
// Host side model that counts interrupt requests arriving on both pins
`timescale 1ns/1ps
module deir_host_model (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  // Interrupt pins
  input  wire logic       int_a_n_in,
  input  wire logic       int_b_n_in,
  // Request counts
  output logic      [7:0] falls_a_out,
  output logic      [7:0] falls_b_out
);
  logic prev_a_q;
  logic prev_b_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Level pins; one service round shows as one falling edge
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_a_q    <= 1'b1;
      prev_b_q    <= 1'b1;
      falls_a_out <= 8'h00;
      falls_b_out <= 8'h00;
    end else begin
      prev_a_q <= int_a_n_in;
      prev_b_q <= int_b_n_in;
      if (prev_a_q && !int_a_n_in) falls_a_out <= falls_a_out + 8'h01;
      if (prev_b_q && !int_b_n_in) falls_b_out <= falls_b_out + 8'h01;
    end
  end
endmodule

// file: testbench/deir_router_bench.sv
// Self-checking bench for the event status and interrupt router
`timescale 1ns/1ps
module deir_router_bench;
  logic        mclk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [31:0] ev      = 32'h0;
  logic [7:0]  rdata;
  logic        int_a_n;
  logic        int_b_n;
  logic [7:0]  falls_a;
  logic [7:0]  falls_b;
  int          mismatches  = 0;
  int          comparisons = 0;

  always #50 mclk_in = ~mclk_in;

  deir_router DUT (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .pattern_err_ch0_in(ev[0]), .pattern_err_ch1_in(ev[1]),
    .lane_buffer_fault_in(ev[2]), .rx_not_ready_in(ev[3]), .sync_ref_jitter_in(ev[4]),
    .cal_done_ch0_in(ev[11]), .amp_protect_ch0_in(ev[8]),
    .cal_done_ch1_in(ev[19]), .amp_protect_ch1_in(ev[16]),
    .synth_locked_in(ev[24]), .synth_unlocked_in(ev[25]),
    .delay_loop_locked_in(ev[28]), .delay_loop_unlocked_in(ev[29]),
    .int_out_a_n(int_a_n), .int_out_b_n(int_b_n));

  deir_host_model host (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .int_a_n_in(int_a_n), .int_b_n_in(int_b_n),
    .falls_a_out(falls_a), .falls_b_out(falls_b));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mask_of(logic [7:0] a);
    if (a < 8'h20 || a > 8'h2B) return 8'h00;
    case (a[1:0])
      2'h0: return deir_pkg::MASK_LINK;
      2'h3: return deir_pkg::MASK_CLOCK;
      default: return deir_pkg::MASK_DAC;
    endcase
  endfunction

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic pins(logic ea, logic eb);
    check("pin a", {7'h00, int_a_n}, {7'h00, ea});
    check("pin b", {7'h00, int_b_n}, {7'h00, eb});
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(string name, logic [7:0] a, logic [7:0] exp);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    @(negedge mclk_in);
    check(name, rdata, exp);
    // End on a rising edge so the next drive lands there
    @(posedge mclk_in);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] fa;
    logic [7:0] fb;
    int         g;
    int         b;
    logic       s;
    void'($urandom(32'hACBF1E8B));
    fa = 8'h00;
    fb = 8'h00;
    repeat (16) @(posedge mclk_in);
    rstn_in <= 1'b1;
    for (int a = 8'h20; a <= 8'h2C; a++) rd_chk("reset", 8'(a), 8'h00);
    @(negedge mclk_in) check("rdata idle", rdata, 8'h00);
    pins(1'b1, 1'b1);
    $display("test reset done");
    // Registers, reserved bits and unmapped places
    for (int a = 8'h1E; a <= 8'h2D; a++) begin
      if (a >= 8'h24 && a <= 8'h27) continue;
      d = 8'($urandom);
      wr_reg(8'(a), d);
      rd_chk("reg rw", 8'(a), d & mask_of(8'(a)));
      wr_reg(8'(a), 8'h00);
    end
    $display("test registers done");
    // Live status follows the condition, both ways
    for (int n = 0; n < 4; n++) begin
      ev <= (n == 0) ? deir_pkg::MASK_ALL : ($urandom & deir_pkg::MASK_ALL);
      idle(8);
      rd_chk("live link", 8'h24, ev[7:0]);
      rd_chk("live dac0", 8'h25, ev[15:8]);
      rd_chk("live dac1", 8'h26, ev[23:16]);
      rd_chk("live clock", 8'h27, ev[31:24]);
      rd_chk("summary live", deir_pkg::OFS_EVENT_SUMMARY, {7'h00, |ev});
      pins(1'b1, 1'b1);
    end
    ev <= 32'h0;
    // Let the synchronisers drain, or a stale condition latches at once
    idle(8);
    $display("test live done");
    // Each source latched, routed, then cleared
    for (int i = 0; i < 32; i++) begin
      if (!deir_pkg::MASK_ALL[i]) continue;
      g = i / 8;
      b = i % 8;
      // Fixed routes on bit 0 of each group so both pins are always hit
      s = (b == 0) ? 1'(g) : 1'($urandom);
      d = 8'h01 << b;
      wr_reg(deir_pkg::OFS_LINK_EVENT_LATCH + 8'(g), d);
      wr_reg(deir_pkg::OFS_LINK_EVENT_PIN_SELECT + 8'(g), s ? d : 8'h00);
      ev[i] <= 1'b1;
      idle(8);
      pins(s, !s);
      fa = fa + 8'(!s);
      fb = fb + 8'(s);
      ev[i] <= 1'b0;
      idle(8);
      rd_chk("latched", 8'h24 + 8'(g), d);
      wr_reg(8'h24 + 8'(g), 8'h00);
      rd_chk("write zero", 8'h24 + 8'(g), d);
      wr_reg(8'h24 + 8'(g), d);
      rd_chk("write one", 8'h24 + 8'(g), 8'h00);
      idle(2);
      pins(1'b1, 1'b1);
      wr_reg(deir_pkg::OFS_LINK_EVENT_LATCH + 8'(g), 8'h00);
      wr_reg(deir_pkg::OFS_LINK_EVENT_PIN_SELECT + 8'(g), 8'h00);
    end
    $display("test latch done");
    // Summary clear, refused while conditions stay high
    for (g = 0; g < 4; g++) wr_reg(8'h20 + 8'(g), deir_pkg::MASK_ALL[8*g +: 8]);
    ev <= deir_pkg::MASK_ALL;
    idle(8);
    pins(1'b0, 1'b1);
    fa = fa + 8'h01;
    wr_reg(deir_pkg::OFS_EVENT_SUMMARY, 8'h01);
    rd_chk("clear held", deir_pkg::OFS_LINK_EVENT_FLAGS, deir_pkg::MASK_LINK);
    ev <= 32'h0;
    idle(8);
    rd_chk("summary", deir_pkg::OFS_EVENT_SUMMARY, 8'h01);
    wr_reg(deir_pkg::OFS_EVENT_SUMMARY, 8'h01);
    for (g = 0; g < 4; g++) rd_chk("summary clear", 8'h24 + 8'(g), 8'h00);
    idle(2);
    pins(1'b1, 1'b1);
    check("host a", falls_a, fa);
    check("host b", falls_b, fb);
    $display("test summary done");
    summarize();
  end

  // Whole run is under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    summarize();
  end
endmodule
